// file: bmdma.sv
// Byte memory DMA engine with AHB-Lite register slave and memory selects
`timescale 1ns/1ns
`default_nettype none
module bmdma (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Boot strap and core coupling
  input  wire logic        byte_boot,
  input  wire logic        ext_busy,
  output logic             halt_core,
  output logic             ctx_clear,
  output logic             restart_zero,
  output logic             done_irq,
  // Core memory selects, active low
  input  wire logic        program_memory_select_n,
  input  wire logic        data_memory_select_n,
  input  wire logic        io_memory_select_n,
  // On-chip memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_pm,
  output logic      [13:0] mem_addr,
  output logic      [23:0] mem_wdata,
  input  wire logic [23:0] mem_rdata,
  // External byte memory pins
  output logic      [13:0] bm_addr,
  output logic      [23:0] bm_data_out,
  output logic             bm_data_hi_oe,
  output logic             bm_data_byte_oe,
  input  wire logic [23:0] bm_data_in,
  output logic             bm_rd_n,
  output logic             bm_wr_n,
  output logic             byte_memory_select_n,
  output logic             composite_select_n
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Last byte index of a word for a format
  function automatic logic [1:0] last_byte(input logic [1:0] fmt);
    case (fmt)
      bmdma_pkg::FMT_PM24: last_byte = 2'h2;
      bmdma_pkg::FMT_DM16: last_byte = 2'h1;
      default:             last_byte = 2'h0;
    endcase
  endfunction

  // Byte lane in the word: 0 bits 23-16, 1 bits 15-8, 2 bits 7-0
  function automatic logic [1:0] lane(input logic [1:0] fmt, input logic [1:0] idx);
    case (fmt)
      bmdma_pkg::FMT_PM24:  lane = idx;
      bmdma_pkg::FMT_DM16:  lane = idx + 2'h1;
      bmdma_pkg::FMT_DM8HI: lane = 2'h1;
      default:              lane = 2'h2;
    endcase
  endfunction

  // Wait states for a count and mode
  function automatic logic [4:0] waits(input logic [3:0] n, input logic mode);
    waits = mode ? {n, 1'b1} : {1'b0, n};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bmdma_pkg::bmdma_state_e st;
    logic        booted;
    logic [13:0] cnt;
    logic [13:0] eaddr;
    logic [7:0]  page;
    logic [13:0] iaddr;
    logic [1:0]  fmt;
    logic        dir;
    logic        hold;
    logic [3:0]  wcount;
    logic        wmode;
    logic [3:0]  composite_select_enables;
    logic        bms_dis;
    logic [23:0] word;
    logic [1:0]  bidx;
    logic [4:0]  wcnt;
    logic        done;
    logic        clr;
    logic        rst0;
    logic        dph;
    logic [13:0] didx;
    logic [31:0] rdata;
  } bmdma_s;

  bmdma_s r;
  bmdma_s next_r;
  logic        addr_ok;
  logic        wr_act;
  logic [13:0] aidx;
  logic [21:0] baddr;
  logic [7:0]  out_byte;
  logic [1:0]  cur_lane;
  logic        strobe;

  assign aidx     = haddr[15:2];
  assign addr_ok  = hsel && hready && (htrans == bmdma_pkg::HTRANS_NONSEQ);
  assign wr_act   = r.dph;
  assign baddr    = {r.page, r.eaddr};
  assign cur_lane = lane(r.fmt, r.bidx);
  assign strobe   = (r.st == bmdma_pkg::ST_STRB);

  // Byte taken from the word for outbound transfers
  always_comb
  begin
    case (cur_lane)
      2'h0:    out_byte = r.word[23:16];
      2'h1:    out_byte = r.word[15:8];
      default: out_byte = r.word[7:0];
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.clr  = 1'b0;
    next_r.rst0 = 1'b0;
    // Boot defaults loaded once after reset release
    if (!r.booted)
    begin
      next_r.booted = 1'b1;
      if (byte_boot)
      begin
        next_r.cnt  = bmdma_pkg::BOOT_COUNT;
        next_r.hold = 1'b1;
        next_r.fmt  = bmdma_pkg::FMT_PM24;
      end
    end
    // Register read in address phase, write in data phase
    next_r.dph = addr_ok && hwrite;
    if (addr_ok)
    begin
      next_r.didx  = aidx;
      next_r.rdata = '0;
      case (aidx)
        bmdma_pkg::IDX_SYSCTL: next_r.rdata[bmdma_pkg::SYS_BMS_DIS] = r.bms_dis;
        bmdma_pkg::IDX_CTRL:   next_r.rdata[3:0] = {r.hold, r.dir, r.fmt};
        bmdma_pkg::IDX_IADDR:  next_r.rdata[13:0] = r.iaddr;
        bmdma_pkg::IDX_EADDR:  next_r.rdata[13:0] = r.eaddr;
        bmdma_pkg::IDX_PAGE:   next_r.rdata[7:0] = r.page;
        bmdma_pkg::IDX_COUNT:  next_r.rdata[13:0] = r.cnt;
        bmdma_pkg::IDX_WAIT:   next_r.rdata = {16'h0000, r.wmode, 11'h000, r.wcount};
        bmdma_pkg::IDX_COMPOSITE_SELECT_ENABLES: next_r.rdata[3:0] = r.composite_select_enables;
        default:               next_r.rdata = '0;
      endcase
    end
    // Setup registers writable only while idle
    if (wr_act && r.st == bmdma_pkg::ST_IDLE)
    begin
      case (r.didx)
        bmdma_pkg::IDX_CTRL:
        begin
          next_r.fmt  = hwdata[1:0];
          next_r.dir  = hwdata[bmdma_pkg::CTRL_DIR];
          next_r.hold = hwdata[bmdma_pkg::CTRL_HOLD];
        end
        bmdma_pkg::IDX_IADDR: next_r.iaddr = hwdata[13:0];
        bmdma_pkg::IDX_EADDR: next_r.eaddr = hwdata[13:0];
        bmdma_pkg::IDX_PAGE:  next_r.page  = hwdata[7:0];
        bmdma_pkg::IDX_COUNT: next_r.cnt   = hwdata[13:0];
        default: ;
      endcase
    end
    if (wr_act)
    begin
      case (r.didx)
        bmdma_pkg::IDX_SYSCTL: next_r.bms_dis = hwdata[bmdma_pkg::SYS_BMS_DIS];
        bmdma_pkg::IDX_WAIT:
        begin
          next_r.wcount = hwdata[3:0];
          next_r.wmode  = hwdata[bmdma_pkg::WAIT_MODE];
        end
        bmdma_pkg::IDX_COMPOSITE_SELECT_ENABLES: next_r.composite_select_enables = hwdata[3:0];
        default: ;
      endcase
    end
    // Transfer engine
    case (r.st)
      bmdma_pkg::ST_IDLE:
      begin
        if (r.booted && r.cnt != '0 && !(wr_act && r.didx == bmdma_pkg::IDX_COUNT))
        begin
          next_r.word = '0;
          next_r.bidx = '0;
          next_r.clr  = r.hold;
          next_r.st   = r.dir ? bmdma_pkg::ST_MRD : bmdma_pkg::ST_ARB;
        end
      end
      bmdma_pkg::ST_MRD:  next_r.st = bmdma_pkg::ST_MCAP;
      bmdma_pkg::ST_MCAP:
      begin
        next_r.word = mem_rdata;
        next_r.st   = bmdma_pkg::ST_ARB;
      end
      bmdma_pkg::ST_ARB:
      begin
        if (!ext_busy)
        begin
          next_r.wcnt = waits(r.wcount, r.wmode);
          next_r.st   = bmdma_pkg::ST_STRB;
        end
      end
      bmdma_pkg::ST_STRB:
      begin
        if (r.wcnt != '0)
          next_r.wcnt = r.wcnt - 5'h01;
        else
        begin
          if (!r.dir)
          begin
            case (cur_lane)
              2'h0:    next_r.word[23:16] = bm_data_in[15:8];
              2'h1:    next_r.word[15:8]  = bm_data_in[15:8];
              default: next_r.word[7:0]   = bm_data_in[15:8];
            endcase
          end
          {next_r.page, next_r.eaddr} = baddr + 22'h000001;
          next_r.bidx = r.bidx + 2'h1;
          if (r.bidx == last_byte(r.fmt))
            next_r.st = r.dir ? bmdma_pkg::ST_FIN : bmdma_pkg::ST_MWR;
          else
            next_r.st = bmdma_pkg::ST_ARB;
        end
      end
      bmdma_pkg::ST_MWR:  next_r.st = bmdma_pkg::ST_FIN;
      bmdma_pkg::ST_FIN:
      begin
        next_r.cnt   = r.cnt - 14'h0001;
        next_r.iaddr = r.iaddr + 14'h0001;
        next_r.st    = bmdma_pkg::ST_IDLE;
        if (r.cnt == 14'h0001)
        begin
          next_r.done = 1'b1;
          next_r.rst0 = r.hold;
        end
      end
      default: next_r.st = bmdma_pkg::ST_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r        <= '0;
      r.st     <= bmdma_pkg::ST_IDLE;
      r.composite_select_enables <= bmdma_pkg::COMPOSITE_SELECT_ENABLES_RST;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus answers; zero wait, always OKAY
  assign hrdata    = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Core coupling; halt spans the idle cycle between words as well
  assign halt_core    = r.hold && ((r.st != bmdma_pkg::ST_IDLE) || (r.cnt != '0));
  assign ctx_clear    = r.clr;
  assign restart_zero = r.rst0;
  assign done_irq     = r.done;

  // One steal cycle per word to on-chip memory only
  assign mem_req   = (r.st == bmdma_pkg::ST_MRD) || (r.st == bmdma_pkg::ST_MWR);
  assign mem_we    = (r.st == bmdma_pkg::ST_MWR);
  assign mem_pm    = (r.fmt == bmdma_pkg::FMT_PM24);
  assign mem_addr  = r.iaddr;
  assign mem_wdata = r.word;

  // Byte pins: page on 23-16, byte on 15-8, offset on address
  assign bm_addr         = r.eaddr;
  assign bm_data_out     = {r.page, out_byte, 8'h00};
  assign bm_data_hi_oe   = strobe;
  assign bm_data_byte_oe = strobe && r.dir;
  assign bm_rd_n         = !(strobe && !r.dir);
  assign bm_wr_n         = !(strobe && r.dir);
  assign byte_memory_select_n = !(strobe && !r.bms_dis);

  // Composite select: pms, dms, bms, io_memory_select enables in bits 0..3
  assign composite_select_n = !((r.composite_select_enables[0] && !program_memory_select_n) ||
                                (r.composite_select_enables[1] && !data_memory_select_n) ||
                                (r.composite_select_enables[2] && strobe) ||
                                (r.composite_select_enables[3] && !io_memory_select_n));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] slen;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slen <= '0;
    else
      slen <= strobe ? slen + 5'h01 : 5'h00;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_bms_disabled: assert property (r.bms_dis |-> byte_memory_select_n)
    else $error("byte select asserted while disabled");
  chk_cms_follow: assert property ((r.composite_select_enables[0] && !program_memory_select_n) ||
      (r.composite_select_enables[2] && strobe) |-> !composite_select_n)
    else $error("composite select missed enabled select");
  chk_arb_yield: assert property ((r.st == bmdma_pkg::ST_ARB && ext_busy)
      |=> r.st == bmdma_pkg::ST_ARB)
    else $error("byte access taken over core access");
  chk_strobe_len: assert property ((strobe && r.wcnt == '0)
      |-> slen == waits(r.wcount, r.wmode))
    else $error("strobe length wrong");
  chk_one_steal: assert property (mem_req |=> !mem_req)
    else $error("more than one memory cycle per word");
  chk_count_dec: assert property (r.st == bmdma_pkg::ST_FIN
      |=> r.cnt == $past(r.cnt) - 14'h0001)
    else $error("word count not decremented");
  chk_done_zero: assert property (done_irq |-> r.cnt == '0 && r.st == bmdma_pkg::ST_IDLE)
    else $error("completion without zero count");
  chk_page_carry: assert property ((strobe && r.wcnt == '0)
      |=> baddr == $past(baddr) + 22'h000001)
    else $error("byte address not sequential");
  chk_halt_hold: assert property (halt_core |-> r.hold)
    else $error("core halted without hold bit");
  chk_halt_gap: assert property (halt_core && r.cnt > 14'h0001 |=> halt_core)
    else $error("core released between words");

  cov_inbound: cover property (r.st == bmdma_pkg::ST_MWR);
  cov_outbound: cover property (r.st == bmdma_pkg::ST_MCAP);
  cov_done_hold: cover property (done_irq && restart_zero);
  cov_page_wrap: cover property (strobe && r.wcnt == '0 && r.eaddr == 14'h3FFF);

endmodule
`default_nettype wire

// file: bmdma_mem_model.sv
// External byte-wide memory model for the byte memory DMA engine
`timescale 1ns/1ns
`default_nettype none
module bmdma_mem_model (
  // Clock
  input  wire logic        hclk,
  // Byte memory pins
  input  wire logic [13:0] bm_addr,
  input  wire logic [23:0] bm_data_out,
  input  wire logic        bm_data_hi_oe,
  input  wire logic        bm_data_byte_oe,
  input  wire logic        bm_rd_n,
  input  wire logic        bm_wr_n,
  output logic      [23:0] bm_data_in
);
  logic [7:0]  mem [int];
  logic [23:0] last = 24'h000000;
  int          loc;
  // -------------------------------------------------------------
  // Byte address and storage
  // -------------------------------------------------------------
  // Page lanes above the 14-bit offset
  assign loc = {10'h000, bm_data_out[23:16], bm_addr};
  // Stored byte, or a fill pattern where nothing was written
  function automatic logic [7:0] rdv(input int a);
    if (mem.exists(a))
      return mem[a];
    return 8'(a ^ (a >> 8) ^ (a >> 15));
  endfunction
  // -------------------------------------------------------------
  // Wire levels
  // -------------------------------------------------------------
  // Undriven lanes flip every cycle so a stale value never passes
  always @*
  begin
    bm_data_in = ~last;
    if (bm_data_hi_oe)
      bm_data_in[23:16] = bm_data_out[23:16];
    if (bm_data_byte_oe)
      bm_data_in[15:8] = bm_data_out[15:8];
    else if (!bm_rd_n)
      bm_data_in[15:8] = rdv(loc);
  end
  // Writes land while the strobe is low
  always @(posedge hclk)
  begin
    last <= bm_data_in;
    if (!bm_wr_n)
      mem[loc] = bm_data_out[15:8];
  end
endmodule
`default_nettype wire

// file: bmdma_pkg.sv
// Constants, states and register map of the byte memory DMA engine
//
// Notes on behaviour
// - Byte space is 256 pages of 16K eight-bit locations.
// - Byte data travels on external data bus bits 15 to 8.
// - 22-bit byte address: page on data bits 23-16, offset on address 13-0.
// - Every byte access is stretched by the four-bit byte wait count.
// - With wait mode set, a count N gives 2N+1 wait states.
// - Format 00 program 24-bit, 01 data 16-bit, 10 upper byte, 11 lower byte.
// - Unused bits of 8-bit data formats are zero.
// - Internal start address, external 14-bit start and 8-bit page set the ends.
// - Direction picks byte space to chip or chip to byte space.
// - Writing a nonzero word count starts the transfer at once.
// - Word count drops after each word; zero stops and raises completion.
// - Sequential byte addresses carry across page boundaries.
// - Bytes per word as format needs, then one cycle to move the word.
// - Processor external accesses win over pending byte accesses.
// - Context hold bit set halts and clears core, restarts at 0 after.
// - One end is always on-chip memory; no external overlay regions.
// - Composite select follows every enabled memory select with same timing.
// - Composite enables reset to 1, except the byte memory one at 0.
// - Byte memory select enabled at reset; when disabled never asserted.
// - Boot mode defaults: zero addresses and direction, format 00, count 32, hold set.
package bmdma_pkg;
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_SYSCTL = 14'h3FFF;
  localparam logic [13:0] IDX_CTRL   = 14'h3FE3;
  localparam logic [13:0] IDX_IADDR  = 14'h3FE1;
  localparam logic [13:0] IDX_EADDR  = 14'h3FE2;
  localparam logic [13:0] IDX_PAGE   = 14'h3FE4;
  localparam logic [13:0] IDX_COUNT  = 14'h3FE5;
  localparam logic [13:0] IDX_WAIT   = 14'h3FFE;
  localparam logic [13:0] IDX_COMPOSITE_SELECT_ENABLES = 14'h3FE6;
  // Field positions
  localparam int SYS_BMS_DIS = 3;
  localparam int CTRL_DIR    = 2;
  localparam int CTRL_HOLD   = 3;
  localparam int WAIT_MODE   = 15;
  // Reset and boot values
  localparam logic [3:0]  COMPOSITE_SELECT_ENABLES_RST = 4'hB;
  localparam logic [13:0] BOOT_COUNT = 14'h0020;
  localparam logic [1:0]  FMT_PM24   = 2'h0;
  localparam logic [1:0]  FMT_DM16   = 2'h1;
  localparam logic [1:0]  FMT_DM8HI  = 2'h2;
  // AHB transfer type
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  // Engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_MRD  = 7'h02,
    ST_MCAP = 7'h04,
    ST_ARB  = 7'h08,
    ST_STRB = 7'h10,
    ST_MWR  = 7'h20,
    ST_FIN  = 7'h40
  } bmdma_state_e;
endpackage

// file: byte_memory_dma_tb.sv
// Self-checking bench for the byte memory DMA engine
`timescale 1ns/1ns
`default_nettype none
module byte_memory_dma_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, fmt;
  logic [2:0]  hsize = 3'h2;
  logic        byte_boot = 1'b1, ext_busy = 1'b0, hreadyout, hresp;
  logic        halt_core, ctx_clear, restart_zero, done_irq;
  logic        program_memory_select_n = 1'b1, data_memory_select_n = 1'b1;
  logic        io_memory_select_n = 1'b1, mem_req, mem_we, mem_pm;
  logic [13:0] mem_addr, bm_addr;
  logic [23:0] mem_wdata, mem_rdata = 24'h0, bm_data_out, bm_data_in;
  logic        bm_data_hi_oe, bm_data_byte_oe, bm_rd_n, bm_wr_n;
  logic        byte_memory_select_n, composite_select_n;
  logic        dir, hcur, wchk = 1'b0, dis = 1'b0, ebr = 1'b0;
  logic        stb, stq = 1'b0, ebq = 1'b0;
  logic [3:0]  en = bmdma_pkg::COMPOSITE_SELECT_ENABLES_RST;
  logic [23:0] exp_w [$];
  logic [7:0]  exp_b [$];
  int          bad_count = 0, tests_run = 0, cyc = 0, len = 0, dn = 0, cc = 0;
  int          bp, iap, wst;
  // Design and external memory
  bmdma bmdma_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .byte_boot, .ext_busy,
    .halt_core, .ctx_clear, .restart_zero, .done_irq, .program_memory_select_n,
    .data_memory_select_n, .io_memory_select_n, .mem_req, .mem_we, .mem_pm,
    .mem_addr, .mem_wdata, .mem_rdata, .bm_addr, .bm_data_out, .bm_data_hi_oe,
    .bm_data_byte_oe, .bm_data_in, .bm_rd_n, .bm_wr_n, .byte_memory_select_n,
    .composite_select_n
  );
  bmdma_mem_model bmdma_mem_model_inst (
    .hclk, .bm_addr, .bm_data_out, .bm_data_hi_oe, .bm_data_byte_oe,
    .bm_rd_n, .bm_wr_n, .bm_data_in
  );
  always #5 hclk = ~hclk;
  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One AHB single transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [13:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {16'h0000, i, 2'h0};
    htrans <= bmdma_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // On-chip memory contents seen by outbound transfers
  function automatic logic [23:0] ow(input logic [13:0] a);
    return {a[7:0] ^ 8'hA5, a[13:6], ~a[7:0]};
  endfunction
  // Expected words or bytes of one transfer, most significant byte first
  task automatic plan(input int cn, input int ia, input int p);
    int nb;
    int sh;
    logic [23:0] w;
    nb = (fmt == 2'h0) ? 3 : (fmt == 2'h1) ? 2 : 1;
    sh = (fmt == 2'h2) ? 8 : 0;
    iap = ia;
    bp = p;
    for (int i = 0; i < cn; i++)
    begin
      w = dir ? ow(14'(ia + i)) : 24'h0;
      for (int k = 0; k < nb; k++)
        if (dir)
          exp_b.push_back(8'(w >> (8 * (nb - 1 - k) + sh)));
        else
          w = (w << 8) | bmdma_mem_model_inst.rdv((p + i * nb + k) & 32'h3FFFFF);
      if (!dir)
        exp_w.push_back(w << sh);
    end
  endtask
  // Wait for completion, then check count, progress and leftovers
  task automatic finish_run(input int cn, input int ia);
    while (dn == 0)
      @(posedge hclk);
    repeat (3) @(posedge hclk);
    chk(dn, 1);
    chk(cc != 0, hcur);
    chk(iap, ia + cn);
    chk(exp_w.size() + exp_b.size(), 0);
    ahb(1'b0, bmdma_pkg::IDX_COUNT, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Program and run one transfer: cfg is hold, direction, format
  task automatic run(input logic [3:0] cfg, input logic [15:0] wv, input int cn,
                     input int pg, input int ea);
    int ia;
    ia = $urandom_range(0, 16'h3F00);
    fmt = cfg[1:0];
    dir = cfg[2];
    hcur = cfg[3];
    wst = wv[15] ? 2 * wv[3:0] + 1 : wv[3:0];
    wchk = 1'b1;
    dn = 0;
    cc = 0;
    plan(cn, ia, (pg << 14) | ea);
    ahb(1'b1, bmdma_pkg::IDX_WAIT, wv);
    ahb(1'b1, bmdma_pkg::IDX_CTRL, cfg);
    ahb(1'b1, bmdma_pkg::IDX_IADDR, ia);
    ahb(1'b1, bmdma_pkg::IDX_EADDR, ea);
    ahb(1'b1, bmdma_pkg::IDX_PAGE, pg);
    ahb(1'b1, bmdma_pkg::IDX_COUNT, cn);
    ahb(1'b1, bmdma_pkg::IDX_COUNT, 32'h3FFF);
    finish_run(cn, ia);
  endtask
  // -------------------------------------------------------------
  // Monitor of memory port, strobes and selects
  // -------------------------------------------------------------
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    program_memory_select_n <= 1'($urandom);
    data_memory_select_n <= 1'($urandom);
    io_memory_select_n <= 1'($urandom);
    ext_busy <= ebr & 1'($urandom);
    if (hresetn)
    begin
      stb = !(bm_rd_n && bm_wr_n);
      chk(composite_select_n, !((!program_memory_select_n & en[0])
        | (!data_memory_select_n & en[1]) | (stb & en[2])
        | (!io_memory_select_n & en[3])));
      chk(byte_memory_select_n, dis | !stb);
      chk(restart_zero, done_irq & hcur);
      chk(halt_core & !hcur, 1'b0);
      chk(ctx_clear & !hcur, 1'b0);
      chk(hresp, 1'b0);
      if (done_irq)
        dn++;
      if (ctx_clear)
        cc++;
      if (mem_req)
      begin
        mem_rdata <= ow(mem_addr);
        chk(halt_core, hcur);
        chk({mem_we, mem_pm, mem_addr}, {!dir, fmt == 2'h0, iap[13:0]});
        iap++;
        if (!dir)
          chk(mem_wdata, exp_w.pop_front());
      end
      if (stb && !stq)
      begin
        chk({bm_data_out[23:16], bm_addr}, bp[21:0]);
        chk({bm_wr_n, bm_rd_n, bm_data_hi_oe, bm_data_byte_oe}, {!dir, dir, 1'b1, dir});
        chk(ebq, 1'b0);
        if (dir)
          chk(bm_data_out[15:8], exp_b.pop_front());
        bp = (bp + 1) & 32'h3FFFFF;
        len = 0;
      end
      if (stb)
        len++;
      if (!stb && stq && wchk)
        chk(len, wst + 1);
      stq = stb;
      ebq = ext_busy;
    end
    // Cycle ceiling; a hang counts as a mismatch
    if (cyc > 50000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h7C81C9AA));
    fmt = bmdma_pkg::FMT_PM24;
    dir = 1'b0;
    hcur = 1'b1;
    plan(32, 0, 0);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    byte_boot <= 1'b0;
    repeat (20) @(posedge hclk);
    chk(halt_core, 1'b1);
    finish_run(32, 0);
    ahb(1'b0, bmdma_pkg::IDX_CTRL, 32'h0);
    chk(rd, 32'h8);
    ahb(1'b0, bmdma_pkg::IDX_COMPOSITE_SELECT_ENABLES, 32'h0);
    chk(rd, 32'hB);
    ahb(1'b0, 14'h0100, 32'h0);
    chk(rd, 32'h0);
    run(4'h3, 16'h0000, 3, 9, 14'h0123);
    run(4'h2, 16'h8003, 2, 200, 14'h1000);
    ebr = 1'b1;
    run(4'h1, 16'h000F, 3, 100, 14'h3FFF);
    ebr = 1'b0;
    run(4'h4, 16'h0001, 3, 5, 14'h3FFE);
    run(4'h7, 16'h0002, 4, 7, 14'h0010);
    ahb(1'b1, bmdma_pkg::IDX_SYSCTL, 32'h8);
    dis <= 1'b1;
    ahb(1'b1, bmdma_pkg::IDX_COMPOSITE_SELECT_ENABLES, 32'hF);
    en <= 4'hF;
    run(4'h9, 16'h8000, 2, 9, 14'h0123);
    run(4'hE, 16'h0000, 2, 3, 14'h0200);
    report_and_stop();
  end
endmodule
`default_nettype wire
